// ### design/baud_tick_gen.sv
// baud divider giving one-cycle half-bit ticks while run is high, held at the reload value otherwise
module baud_tick_gen (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic reload,
  input wire logic wide,
  input wire rx_pkg::byte_t div_low,
  input wire rx_pkg::byte_t div_high,
  output logic tick
);
  import rx_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } baud_regs_t;

  baud_regs_t q;
  baud_regs_t d;
  logic [15:0] load;

  // ==========================================================
  // reload value: 8 or 16 bit divisor
  always_comb begin
    load = wide ? {div_high, div_low} : {8'h00, div_low};
    d = q;
    d.tick = 1'b0;
    if (!run || reload) begin
      d.count = load;
    end else if (q.count == 16'h0000) begin
      d.count = load;
      d.tick = 1'b1;
    end else begin
      d.count = q.count - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule

// ### design/bit_sync.sv
// two flip-flop synchroniser for one pin level
module bit_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  import rx_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_regs_t;

  sync_regs_t q;
  sync_regs_t d;

  // ==========================================================
  // first stage feeds only the second
  always_comb begin
    d = q;
    d.meta = pin;
    d.stable = q.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.stable;
endmodule

// ### design/rx_pkg.sv
// constants, offsets and types of the synchronous master receiver
package rx_pkg;

  // ==========================================================
  // register port
  typedef logic [2:0] addr_t;
  typedef logic [7:0] byte_t;

  localparam addr_t ADR_STATUS_CONTROL = 3'h0;
  localparam addr_t ADR_DATA_PORT = 3'h1;
  localparam addr_t ADR_DIVISOR_LOW = 3'h2;
  localparam addr_t ADR_DIVISOR_HIGH = 3'h3;
  localparam addr_t ADR_MODE = 3'h4;
  localparam addr_t ADR_IRQ = 3'h5;

  // ==========================================================
  // receive_status_control fields
  localparam int PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_BIT = 6;
  localparam int SINGLE_RX_BIT = 5;
  localparam int CONT_RX_BIT = 4;
  localparam int ADDR_DETECT_BIT = 3;
  localparam byte_t STATUS_CONTROL_RESET = 8'h00;

  // mode register fields
  localparam int SYNC_MODE_BIT = 0;
  localparam int MASTER_SEL_BIT = 1;
  localparam int POLARITY_BIT = 2;
  localparam int WIDE_DIV_BIT = 3;
  localparam int HIGH_SPEED_BIT = 4;
  localparam byte_t MODE_RESET = 8'h00;

  // irq register fields
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;

  // divisor reset values
  localparam byte_t DIVISOR_RESET = 8'h00;

  // ==========================================================
  // character shape and buffer
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] FIFO_FULL = 2'h2;

  // shift engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } rx_state_t;

endpackage

// ### design/sync_master_serial_receiver.sv
// receive path of a serial port running as synchronous master
// ==========================================================
// Notes on behaviour
// - master receive only with sync mode, port enable, master select
// - interrupt enable plus complete flag give a receive interrupt
// - reception starts on single or continuous receive enable
// - complete flag sets once a character sits in the buffer
// - interrupt request is complete flag and interrupt enable
// - data port shows low eight bits of the oldest character
// - clearing continuous receive or port enable clears overrun
// - bit 7 port enable; zero holds the port in reset
// - bit 6 selects nine-bit characters, else eight
// - bit 5 single receive, ignored outside synchronous mode
// - single receive fetches exactly one character
// - status layout 7..0, top five writable, all reset zero
// - continuous receive overrides single receive until cleared
// - single receive clears itself after its character
// - third character with two buffered sets overrun, data kept
module sync_master_serial_receiver (
  input wire logic clk,
  input wire logic rst_b,
  input wire rx_pkg::addr_t addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire rx_pkg::byte_t wr_data,
  output rx_pkg::byte_t rd_data,
  input wire logic receive_data_pin,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_b,
  output logic rx_irq
);
  import rx_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic port_enable;
    logic nine_bit_receive_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic overrun_error_flag;
    byte_t baud_divisor_low;
    byte_t baud_divisor_high;
    logic sync_mode_select;
    logic clock_source_master_select;
    logic clock_polarity_select;
    logic wide_divisor_select;
    logic high_speed_divisor_select;
    logic receive_interrupt_enable;
    rx_state_t st;
    logic [3:0] bit_count;
    logic [8:0] shift;
    logic [1:0][8:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic ck;
    byte_t rdata;
  } rx_regs_t;

  rx_regs_t q;
  rx_regs_t d;
  logic data_level;
  logic tick;
  logic mode_ok;
  logic active;
  logic receive_complete_flag;
  logic [8:0] top;
  logic [8:0] char_in;
  logic [3:0] last_bit;
  logic char_done;
  logic push;
  logic pop;
  logic wr_idx;
  logic div_reload;

  // ==========================================================
  // pin synchroniser and baud divider
  bit_sync u_data_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(receive_data_pin),
    .level(data_level)
  );

  // divisor writes restart the divider at once
  assign div_reload = wr_en &&
    (addr == ADR_DIVISOR_LOW || addr == ADR_DIVISOR_HIGH);

  baud_tick_gen u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .run(active || q.st != ST_IDLE),
    .reload(div_reload),
    .wide(q.wide_divisor_select),
    .div_low(q.baud_divisor_low),
    .div_high(q.baud_divisor_high),
    .tick(tick)
  );

  // ==========================================================
  // derived terms
  assign mode_ok = q.sync_mode_select && q.port_enable &&
    q.clock_source_master_select;
  assign active = mode_ok && !q.overrun_error_flag &&
    (q.continuous_receive_enable || q.single_receive_enable);
  assign receive_complete_flag = q.count != 2'h0;
  assign top = q.fifo[q.rd_ptr];
  assign wr_idx = q.rd_ptr ^ q.count[0];
  assign last_bit = q.nine_bit_receive_select ? LAST_BIT_9
    : LAST_BIT_8;
  assign char_in = q.nine_bit_receive_select ? q.shift
    : {1'b0, q.shift[8:1]};

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.rdata = 8'h00;
    char_done = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    // register writes
    if (wr_en) begin
      unique case (addr)
        ADR_STATUS_CONTROL: begin
          d.port_enable = wr_data[PORT_ENABLE_BIT];
          d.nine_bit_receive_select = wr_data[NINE_BIT_BIT];
          d.single_receive_enable = wr_data[SINGLE_RX_BIT];
          d.continuous_receive_enable = wr_data[CONT_RX_BIT];
          d.address_detect_enable = wr_data[ADDR_DETECT_BIT];
          if (!wr_data[CONT_RX_BIT]) begin
            d.overrun_error_flag = 1'b0;
          end
        end
        ADR_DIVISOR_LOW: d.baud_divisor_low = wr_data;
        ADR_DIVISOR_HIGH: d.baud_divisor_high = wr_data;
        ADR_MODE: begin
          d.sync_mode_select = wr_data[SYNC_MODE_BIT];
          d.clock_source_master_select = wr_data[MASTER_SEL_BIT];
          d.clock_polarity_select = wr_data[POLARITY_BIT];
          d.wide_divisor_select = wr_data[WIDE_DIV_BIT];
          d.high_speed_divisor_select = wr_data[HIGH_SPEED_BIT];
        end
        ADR_IRQ: d.receive_interrupt_enable = wr_data[IRQ_ENABLE_BIT];
        default: ;
      endcase
    end
    // register reads, answer in the next cycle only
    if (rd_en) begin
      unique case (addr)
        ADR_STATUS_CONTROL: begin
          d.rdata = {q.port_enable, q.nine_bit_receive_select,
            q.single_receive_enable, q.continuous_receive_enable,
            q.address_detect_enable, 1'b0, q.overrun_error_flag,
            top[8]};
        end
        ADR_DATA_PORT: begin
          d.rdata = top[7:0];
          pop = receive_complete_flag;
          // overrun from single receive clears on a data read
          if (!q.continuous_receive_enable) begin
            d.overrun_error_flag = 1'b0;
          end
        end
        ADR_DIVISOR_LOW: d.rdata = q.baud_divisor_low;
        ADR_DIVISOR_HIGH: d.rdata = q.baud_divisor_high;
        ADR_MODE: begin
          d.rdata = {3'h0, q.high_speed_divisor_select,
            q.wide_divisor_select, q.clock_polarity_select,
            q.clock_source_master_select, q.sync_mode_select};
        end
        ADR_IRQ: begin
          d.rdata = {6'h00, receive_complete_flag,
            q.receive_interrupt_enable};
        end
        default: d.rdata = 8'h00;
      endcase
    end
    // idle clock follows the polarity select at once
    if (q.st == ST_IDLE) begin
      d.ck = q.clock_polarity_select;
    end
    // shift engine: leading edge, sample on trailing edge
    if (!active && q.st != ST_IDLE && !q.overrun_error_flag) begin
      d.st = ST_IDLE;
      d.ck = q.clock_polarity_select;
    end else if (tick) begin
      unique case (q.st)
        ST_IDLE: begin
          if (active) begin
            d.st = ST_LEAD;
            d.ck = !q.clock_polarity_select;
            d.bit_count = 4'h0;
          end else begin
            d.ck = q.clock_polarity_select;
          end
        end
        ST_LEAD: begin
          d.shift = {data_level, q.shift[8:1]};
          d.ck = q.clock_polarity_select;
          d.st = ST_TRAIL;
        end
        ST_TRAIL: begin
          if (q.bit_count == last_bit) begin
            char_done = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.bit_count = q.bit_count + 4'h1;
            d.ck = !q.clock_polarity_select;
            d.st = ST_LEAD;
          end
        end
      endcase
    end
    // character placement or overrun, set wins over clear
    if (char_done) begin
      if (q.count == FIFO_FULL && !pop) begin
        d.overrun_error_flag = 1'b1;
      end else begin
        push = 1'b1;
        d.fifo[wr_idx] = char_in;
      end
      if (q.single_receive_enable && !q.continuous_receive_enable) begin
        d.single_receive_enable = 1'b0;
      end
    end
    // buffer pointers
    if (pop) begin
      d.rd_ptr = !q.rd_ptr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
    // disabled port is held in reset
    if (!q.port_enable) begin
      d.st = ST_IDLE;
      d.bit_count = 4'h0;
      d.count = 2'h0;
      d.rd_ptr = 1'b0;
      d.overrun_error_flag = 1'b0;
      d.ck = q.clock_polarity_select;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data = q.rdata;
  assign transmit_clock_pin_out = q.ck;
  assign transmit_clock_pin_oe_b = !mode_ok;
  assign rx_irq = receive_complete_flag &&
    q.receive_interrupt_enable;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_irq_level: assert property (
    rx_irq == (q.count != 2'h0 && q.receive_interrupt_enable))
    else $error("interrupt request does not follow flag and enable");

  a_master_gate: assert property (
    !mode_ok |=> q.st == ST_IDLE)
    else $error("shift engine runs without master mode");

  a_no_start: assert property (
    (q.st == ST_IDLE && !active) |=> q.st == ST_IDLE)
    else $error("reception started without a receive enable");

  a_push_flag: assert property (
    push |=> receive_complete_flag && q.count != 2'h0)
    else $error("complete flag not set after a character");

  a_overrun_keep: assert property (
    (char_done && q.count == FIFO_FULL && !pop && q.port_enable)
    |=> q.overrun_error_flag && q.count == FIFO_FULL &&
      $stable(q.fifo))
    else $error("overrun not flagged or buffer overwritten");

  a_cont_clear: assert property (
    (wr_en && addr == ADR_STATUS_CONTROL && !wr_data[CONT_RX_BIT]
      && !char_done) |=> !q.overrun_error_flag)
    else $error("overrun survives clearing continuous receive");

  a_port_reset: assert property (
    !q.port_enable |=> q.count == 2'h0 && q.st == ST_IDLE)
    else $error("disabled port not held in reset");

  a_single_done: assert property (
    (char_done && q.single_receive_enable &&
      !q.continuous_receive_enable) |=> !q.single_receive_enable)
    else $error("single receive not cleared after its character");

  a_char_length: assert property (
    char_done |-> q.bit_count ==
      (q.nine_bit_receive_select ? LAST_BIT_9 : LAST_BIT_8))
    else $error("character length does not follow nine-bit select");

  a_read_oldest: assert property (
    (rd_en && addr == ADR_DATA_PORT) |=> rd_data == $past(top[7:0]))
    else $error("data port does not show oldest character");

  a_clock_idle: assert property (
    (q.st == ST_TRAIL && tick && q.bit_count == last_bit
      && active) |=> transmit_clock_pin_out == q.clock_polarity_select)
    else $error("shift clock not at idle level after character");

  a_idle_clock: assert property (
    (q.st == ST_IDLE && !(tick && active))
    |=> transmit_clock_pin_out == $past(q.clock_polarity_select))
    else $error("shift clock not at idle level between characters");

  a_single_once: assert property (
    (char_done && !q.continuous_receive_enable &&
      !(wr_en && addr == ADR_STATUS_CONTROL)) |=> !active)
    else $error("single receive fetched more than one character");

  a_overrun_hold: assert property (
    q.overrun_error_flag |=> q.st == ST_IDLE)
    else $error("character accepted while overrun is set");

  c_cont_second: cover property (
    push && q.continuous_receive_enable && q.count == 2'h1);
  c_single_char: cover property (
    char_done && q.single_receive_enable &&
    !q.continuous_receive_enable);
  c_overrun: cover property (
    $rose(q.overrun_error_flag));
  c_nine_bit: cover property (
    push && q.nine_bit_receive_select);
endmodule

// ### dv/sync_master_serial_receiver_tb_top.sv
// self-checking bench of the synchronous master receiver
module sync_master_serial_receiver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_pkg::*;

  logic clk, rst_b, wr_en, rd_en, dpin, sck, sck_oe_b, rx_irq;
  logic pol, nine, started;
  addr_t addr;
  byte_t wr_data, rd_data, v;
  logic [8:0] word, hd;
  logic [31:0] seed;
  logic [8:0] exp_q[$];
  int failures, checks, starts;
  bit ovr_m;

  // ==========================================================
  // instances and clock
  sync_master_serial_receiver i_sync_master_serial_receiver (
    .clk(clk),
    .rst_b(rst_b),
    .addr(addr),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .receive_data_pin(dpin),
    .transmit_clock_pin_out(sck),
    .transmit_clock_pin_oe_b(sck_oe_b),
    .rx_irq(rx_irq)
  );

  sync_slave_model i_sync_slave_model (
    .sck(sck),
    .sck_oe_b(sck_oe_b),
    .pol(pol),
    .nine(nine),
    .word(word),
    .data(dpin), // plain digital data pin
    .started(started)
  );

  always #2.5 clk = ~clk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input byte_t e, input byte_t g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input addr_t a, input byte_t d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input addr_t a, output byte_t d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rd_data;
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (rx_irq === 1'b1) begin
        break;
      end
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // model of the two-deep buffer; a third character overruns
  always @(posedge started) begin
    starts++;
    if (exp_q.size() < 2) begin
      exp_q.push_back(nine ? word : {1'b0, word[7:0]});
    end else begin
      ovr_m = 1'b1;
    end
    seed = lfsr(seed);
    word <= seed[8:0];
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = '0;
    pol = 1'b0;
    nine = 1'b0;
    seed = lfsr(32'hD58A);
    word = seed[8:0];
    failures = 0;
    checks = 0;
    starts = 0;
    ovr_m = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped place, access kinds
    for (int a = 0; a < 8; a++) begin
      rd(addr_t'(a), v);
      chk("reset value", 8'h00, v);
    end
    wr(3'h6, 8'hFF);
    rd(3'h6, v);
    chk("unmapped", 8'h00, v);
    wr(ADR_STATUS_CONTROL, 8'hFF);
    rd(ADR_STATUS_CONTROL, v);
    chk("status access", 8'hF8, v);
    wr(ADR_STATUS_CONTROL, 8'h00);
    // without synchronous mode nothing is received
    wr(ADR_DIVISOR_LOW, 8'h05);
    wr(ADR_IRQ, 8'h01);
    wr(ADR_MODE, 8'h02);
    wr(ADR_STATUS_CONTROL, 8'hA0);
    repeat (300) @(posedge clk);
    chk("start count", 8'h00, 8'(starts));
    chk("irq", 8'h00, {7'h00, rx_irq});
    wr(ADR_STATUS_CONTROL, 8'h00);
    // single characters: 8 bits idle low, 9 bits idle high wide divisor
    for (int k = 0; k < 2; k++) begin
      pol <= k[0];
      nine <= k[0];
      wr(ADR_MODE, k ? 8'h0F : 8'h03);
      wr(ADR_STATUS_CONTROL, 8'h80);
      @(posedge clk);
      chk("clock idle", {7'h00, pol}, {7'h00, sck});
      chk("clock enable", 8'h00, {7'h00, sck_oe_b});
      wr(ADR_STATUS_CONTROL, {1'b1, k[0], 6'h20});
      wait_irq();
      rd(ADR_IRQ, v);
      chk("irq flag", 8'h03, v);
      hd = exp_q.pop_front();
      rd(ADR_STATUS_CONTROL, v);
      chk("status", {1'b1, k[0], 5'h00, hd[8]}, v);
      rd(ADR_DATA_PORT, v);
      chk("data", hd[7:0], v);
      @(posedge clk);
      chk("irq", 8'h00, {7'h00, rx_irq});
      chk("start count", 8'(k + 1), 8'(starts));
    end
    // continuous reception into a full buffer
    nine <= 1'b0;
    pol <= 1'b0;
    wr(ADR_MODE, 8'h03);
    wr(ADR_STATUS_CONTROL, 8'h90);
    v = 8'h00;
    for (int i = 0; i < 400 && v[1] !== 1'b1; i++) begin
      rd(ADR_STATUS_CONTROL, v);
    end
    repeat (300) @(posedge clk);
    chk("start count", 8'h05, 8'(starts));
    rd(ADR_STATUS_CONTROL, v);
    chk("status", 8'h90 | {6'h00, ovr_m, 1'b0}, v);
    wr(ADR_IRQ, 8'h00);
    @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, rx_irq});
    rd(ADR_IRQ, v);
    chk("irq flag", 8'h02, v);
    for (int i = 0; i < 2; i++) begin
      hd = exp_q.pop_front();
      rd(ADR_DATA_PORT, v);
      chk("data", hd[7:0], v);
    end
    rd(ADR_STATUS_CONTROL, v);
    chk("status", 8'h90 | {6'h00, ovr_m, 1'b0}, v);
    wr(ADR_STATUS_CONTROL, 8'h80);
    ovr_m = 1'b0;
    rd(ADR_STATUS_CONTROL, v);
    chk("status", 8'h80, v);
    // port disable holds the port in reset
    wr(ADR_STATUS_CONTROL, 8'h00);
    @(posedge clk);
    chk("clock enable", 8'h01, {7'h00, sck_oe_b});
    complete_run();
  end
endmodule

// ### dv/sync_slave_model.sv
// serial slave model feeding characters to the receive data pin
module sync_slave_model (
  input wire logic sck,
  input wire logic sck_oe_b,
  input wire logic pol,
  input wire logic nine,
  input wire logic [8:0] word,
  output logic data,
  output logic started
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sr;
  int idx;

  // ==========================================================
  // shifting
  initial begin
    data = 1'b0;
    started = 1'b0;
    sr = '0;
    idx = 0;
  end

  // new bit on each leading edge, lsb first
  always @(sck) begin
    if (!sck_oe_b && sck !== pol) begin
      if (idx == 0) begin
        sr = word;
      end
      started = (idx == 0);
      data = sr[idx];
      idx = (idx + 1 == (nine ? 9 : 8)) ? 0 : idx + 1;
    end
  end

  // released line shows the inverse of its last level
  always @(posedge sck_oe_b) begin
    data = ~data;
    idx = 0;
  end
endmodule
